// *** pkg/ubf_baud_if.sv ***
// Interface carrying baud settings from register file to the divider.
// Assumes one clock domain, shared by both ends.
`timescale 1ns/1ps
interface ubf_baud_if;
	logic [14:0] divisor;
	ubf_pkg::ubf_src_type source;
	modport ctrl (output divisor, output source);
	modport gen (input divisor, input source);
endinterface : ubf_baud_if

// *** pkg/ubf_cfg.svh ***
// Constants for the serial port control block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and design files.
`ifndef UBF_CFG_SVH
`define UBF_CFG_SVH

`define UBF_OFS_DATA 3'h0
`define UBF_OFS_IER 3'h1
`define UBF_OFS_FCR 3'h2
`define UBF_OFS_LCR 3'h3
`define UBF_LCR_DIVISOR_ACCESS_LATCH 7
`define UBF_DLH_CLKSEL 7
`define UBF_DLH_DIV_MSB 6
`define UBF_DLH_DIV_LSB 0
`define UBF_IER_MSI 3
`define UBF_IER_LSI 2
`define UBF_IER_THRI 1
`define UBF_IER_RDAI 0
`define UBF_FCR_EN 0
`define UBF_FCR_RXCLR 1
`define UBF_FCR_TXCLR 2
`define UBF_FCR_DMA 3
`define UBF_FCR_THR_HI 7
`define UBF_FCR_THR_LO 6
`define UBF_RST_BYTE 8'h00
`define UBF_RST_THR 2'h0
`define UBF_RST_IER 4'h0
`define UBF_THR_1 5'h01
`define UBF_THR_4 5'h04
`define UBF_THR_8 5'h08
`define UBF_THR_14 5'h0e
`define UBF_IIR_NONE 8'h01
`define UBF_FIFO_EN_BITS 2'h3

`endif

// *** pkg/ubf_pkg.sv ***
// Types shared by the serial port control block.
// Assumes ubf_cfg.svh is on the include path.
`include "ubf_cfg.svh"
package ubf_pkg;
	typedef enum logic [1:0] {
		UBF_SRC_SLOW = 2'b00,
		UBF_SRC_FAST = 2'b01,
		UBF_SRC_EXT = 2'b10
	} ubf_src_type;
endpackage : ubf_pkg

// *** rtl/ubf_baud_gen.sv ***
// Baud tick generator: divides the chosen baud clock by the divisor.
// Assumes the three baud clock levels are already synchronised.
`timescale 1ns/1ps
`include "ubf_cfg.svh"
module ubf_baud_gen
	import ubf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Settings and sources
	ubf_baud_if.gen cfg,
	input wire logic slow_clk_i,
	input wire logic fast_clk_i,
	input wire logic ext_clk_i,
	// Result
	output logic tick_o
);
	logic src_prev;
	logic [14:0] count;
	logic tick;
	logic next_src_prev;
	logic [14:0] next_count;
	logic next_tick;
	logic src_now;

	always_comb begin
		case (cfg.source)
			UBF_SRC_SLOW: src_now = slow_clk_i;
			UBF_SRC_FAST: src_now = fast_clk_i;
			UBF_SRC_EXT: src_now = ext_clk_i;
			default: src_now = slow_clk_i;
		endcase
		next_src_prev = src_now;
		next_count = count;
		next_tick = 1'b0;
		// Zero divisor stops the ticks rather than dividing by zero
		if (src_now && !src_prev && cfg.divisor != 15'h0000) begin
			if (count >= cfg.divisor - 15'h0001) begin
				next_count = 15'h0000;
				next_tick = 1'b1;
			end else begin
				next_count = count + 15'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			src_prev <= 1'b0;
			count <= 15'h0000;
			tick <= 1'b0;
		end else begin
			src_prev <= next_src_prev;
			count <= next_count;
			tick <= next_tick;
		end
	end

	assign tick_o = tick;
endmodule : ubf_baud_gen

// *** rtl/ubf_ctrl.sv ***
// Serial port control registers: divisor, interrupt enables, FIFO control.
// Assumes a synchronous byte register port; baud clocks arrive unsynced.
//
// Summary of operation
// - Clock select bit picks slow or fast clock
// - Upper divisor bits 6:0, read-write, reset zero
// - All enables clear: no interrupt, ident inhibited
// - Enable bit 3 allows modem status interrupt
// - Enable bit 2 allows line status interrupt
// - Enable bit 1 allows holding-empty interrupt
// - Enable bit 0 allows data and timeout
// - FIFO control write-only, reads give identification
// - Bits 7:6 select receive interrupt threshold
// - DMA mode bit has no effect
// - Bit 2 flushes transmit queue, self-clearing
// - Bit 1 flushes receive queue, self-clearing
// - Bit 0 enables queues; clearing empties them
// - Threshold codes: 1, 4, 8, 14 bytes
// - Divisor latch steers offset 1 only
// - Clock source bit picks external clock
`timescale 1ns/1ps
`include "ubf_cfg.svh"
module ubf_ctrl
	import ubf_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Neighbouring register state
	input wire logic divisor_access_latch_i,
	input wire logic [7:0] divisor_lower_i,
	input wire logic external_baud_select_i,
	input wire logic [7:0] interrupt_ident_i,
	// Interrupt sources from the data path
	input wire logic line_error_i,
	input wire logic rx_data_i,
	input wire logic rx_timeout_i,
	input wire logic tx_holding_empty_i,
	input wire logic modem_change_i,
	// Baud clocks from pins
	input wire logic slow_clk_i,
	input wire logic fast_clk_i,
	input wire logic ext_clk_i,
	// Outputs
	output logic baud_tick_o,
	output logic irq_o,
	output logic ident_inhibit_o,
	output logic queues_enable_o,
	output logic tx_queue_flush_o,
	output logic rx_queue_flush_o,
	output logic [4:0] rx_threshold_o
);
	ubf_baud_if baud ();

	// Two-stage synchronisers for the baud clocks
	logic [2:0] clk_s1;
	logic [2:0] clk_s2;

	logic [7:0] baud_divisor_high;
	logic [3:0] interrupt_enables;
	logic queues_enable;
	logic [1:0] rx_threshold_code;
	logic tx_flush;
	logic rx_flush;
	logic [7:0] rdata;
	logic irq;
	logic inhibit;
	logic [4:0] threshold;

	logic [7:0] next_baud_divisor_high;
	logic [3:0] next_interrupt_enables;
	logic next_queues_enable;
	logic [1:0] next_rx_threshold_code;
	logic next_tx_flush;
	logic next_rx_flush;
	logic [7:0] next_rdata;
	logic next_irq;
	logic next_inhibit;
	logic [4:0] next_threshold;
	logic wr_ier;
	logic wr_dlh;
	logic wr_fcr;

	function automatic logic [4:0] thr_bytes(input logic [1:0] code);
		case (code)
			2'h0: thr_bytes = `UBF_THR_1;
			2'h1: thr_bytes = `UBF_THR_4;
			2'h2: thr_bytes = `UBF_THR_8;
			2'h3: thr_bytes = `UBF_THR_14;
			default: thr_bytes = `UBF_THR_1;
		endcase
	endfunction : thr_bytes

	// Offset 1 is shared: the latch picks divisor or enables
	function automatic logic divisor_sel(input logic [2:0] addr,
		input logic latch);
		divisor_sel = addr == `UBF_OFS_IER && latch;
	endfunction : divisor_sel

	function automatic logic enables_sel(input logic [2:0] addr,
		input logic latch);
		enables_sel = addr == `UBF_OFS_IER && !latch;
	endfunction : enables_sel

	always_comb begin
		wr_dlh = reg_wr_i
			&& divisor_sel(reg_addr_i, divisor_access_latch_i);
		wr_ier = reg_wr_i
			&& enables_sel(reg_addr_i, divisor_access_latch_i);
		wr_fcr = reg_wr_i && reg_addr_i == `UBF_OFS_FCR;
		next_baud_divisor_high = wr_dlh ? reg_wdata_i
			: baud_divisor_high;
		next_interrupt_enables = wr_ier
			? reg_wdata_i[`UBF_IER_MSI:`UBF_IER_RDAI]
			: interrupt_enables;
		next_queues_enable = queues_enable;
		next_rx_threshold_code = rx_threshold_code;
		next_tx_flush = 1'b0;
		next_rx_flush = 1'b0;
		// Bit 3 is accepted and dropped on purpose
		if (wr_fcr) begin
			next_queues_enable = reg_wdata_i[`UBF_FCR_EN];
			// Fields only take with enable set
			if (reg_wdata_i[`UBF_FCR_EN]) begin
				next_rx_threshold_code =
					reg_wdata_i[`UBF_FCR_THR_HI:`UBF_FCR_THR_LO];
				next_tx_flush = reg_wdata_i[`UBF_FCR_TXCLR];
				next_rx_flush = reg_wdata_i[`UBF_FCR_RXCLR];
			end else begin
				// Leaving FIFO mode empties both queues
				next_tx_flush = 1'b1;
				next_rx_flush = 1'b1;
			end
		end
		next_threshold = thr_bytes(next_rx_threshold_code);
		next_rdata = `UBF_RST_BYTE;
		case (reg_addr_i)
			`UBF_OFS_IER: begin
				if (divisor_access_latch_i)
					next_rdata = baud_divisor_high;
				else
					next_rdata = {`UBF_RST_IER, interrupt_enables};
			end
			`UBF_OFS_FCR: begin
				// Reads see identification, never FIFO control
				next_rdata = inhibit ? `UBF_IIR_NONE : interrupt_ident_i;
			end
			default: next_rdata = `UBF_RST_BYTE;
		endcase
		// Read data holds until the next read strobe
		if (!reg_rd_i)
			next_rdata = rdata;
		next_inhibit = interrupt_enables == `UBF_RST_IER;
		// Timeout only counts while the queues run
		next_irq = (interrupt_enables[`UBF_IER_MSI] && modem_change_i)
			|| (interrupt_enables[`UBF_IER_LSI] && line_error_i)
			|| (interrupt_enables[`UBF_IER_THRI]
				&& tx_holding_empty_i)
			|| (interrupt_enables[`UBF_IER_RDAI] && (rx_data_i
				|| (queues_enable && rx_timeout_i)));
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_s1 <= 3'h0;
			clk_s2 <= 3'h0;
			baud_divisor_high <= `UBF_RST_BYTE;
			interrupt_enables <= `UBF_RST_IER;
			queues_enable <= 1'b0;
			rx_threshold_code <= `UBF_RST_THR;
			tx_flush <= 1'b0;
			rx_flush <= 1'b0;
			rdata <= `UBF_RST_BYTE;
			irq <= 1'b0;
			inhibit <= 1'b1;
			threshold <= `UBF_THR_1;
		end else begin
			clk_s1 <= {ext_clk_i, fast_clk_i, slow_clk_i};
			clk_s2 <= clk_s1;
			baud_divisor_high <= next_baud_divisor_high;
			interrupt_enables <= next_interrupt_enables;
			queues_enable <= next_queues_enable;
			rx_threshold_code <= next_rx_threshold_code;
			tx_flush <= next_tx_flush;
			rx_flush <= next_rx_flush;
			rdata <= next_rdata;
			irq <= next_irq;
			inhibit <= next_inhibit;
			threshold <= next_threshold;
		end
	end

	// Source choice and divisor packing
	assign baud.source = external_baud_select_i ? UBF_SRC_EXT
		: (baud_divisor_high[`UBF_DLH_CLKSEL] ? UBF_SRC_FAST
		: UBF_SRC_SLOW);
	assign baud.divisor = {
		baud_divisor_high[`UBF_DLH_DIV_MSB:`UBF_DLH_DIV_LSB],
		divisor_lower_i};

	ubf_baud_gen u_gen (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.cfg(baud.gen),
		.slow_clk_i(clk_s2[0]),
		.fast_clk_i(clk_s2[1]),
		.ext_clk_i(clk_s2[2]),
		.tick_o(baud_tick_o)
	);

	// Every output is taken straight from a flop
	assign reg_rdata_o = rdata;
	assign irq_o = irq;
	assign ident_inhibit_o = inhibit;
	assign queues_enable_o = queues_enable;
	assign tx_queue_flush_o = tx_flush;
	assign rx_queue_flush_o = rx_flush;
	assign rx_threshold_o = threshold;
endmodule : ubf_ctrl

// *** tb/testbench.sv ***
// Bench for ubf_ctrl: registers, interrupt gating, queues, baud.
// Assumes the far model supplies the baud clocks.
`timescale 1ns/1ps
module testbench;
	logic ref_clk_i, rst_n_i, reg_wr_i, reg_rd_i, latch, ext_sel;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, lower, ident, lfsr;
	logic [4:0] src, rx_threshold_o;
	logic slow, fast, ext, tick, irq_o, ident_inhibit_o, queues_enable_o;
	logic tx_queue_flush_o, rx_queue_flush_o;
	logic [4:0] thr_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
	int miscompares, n_compared, cyc, ticks, ns, nf, nx, n2;
	logic [7:0] expq [$];
	ubf_ctrl ubf_ctrl_inst (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .divisor_access_latch_i(latch),
		.divisor_lower_i(lower), .external_baud_select_i(ext_sel),
		.interrupt_ident_i(ident), .line_error_i(src[2]), .rx_data_i(src[0]),
		.rx_timeout_i(src[4]), .tx_holding_empty_i(src[1]),
		.modem_change_i(src[3]), .slow_clk_i(slow), .fast_clk_i(fast),
		.ext_clk_i(ext), .baud_tick_o(tick), .irq_o, .ident_inhibit_o,
		.queues_enable_o, .tx_queue_flush_o, .rx_queue_flush_o,
		.rx_threshold_o);
	ubf_far_model ubf_far_model_inst (.slow_clk_o(slow), .fast_clk_o(fast),
		.ext_clk_o(ext));
	initial begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = !ref_clk_i;
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input string what, input logic [7:0] e, g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	// One access; reads leave their expected byte in the queue
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = w;
		reg_rd_i = !w;
		if (!w) expq.push_back(d);
		@(negedge ref_clk_i);
		{reg_wr_i, reg_rd_i} = 2'h0;
	endtask : bus
	task automatic wait_chk(input string what, input logic e);
		repeat (2) @(negedge ref_clk_i);
		chk(what, {7'h0, e}, {7'h0, irq_o});
	endtask : wait_chk
	// Skips pipeline settling so an old setting cannot leak in
	task automatic count(output int n);
		int t0;
		repeat (8) @(negedge ref_clk_i);
		t0 = ticks;
		repeat (400) @(negedge ref_clk_i);
		n = ticks - t0;
	endtask : count
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (tick) ticks <= ticks + 1;
		if (cyc == 20000) begin
			miscompares++;
			finish_test();
		end
		if (reg_rd_i) begin
			@(negedge ref_clk_i);
			chk("rdata", expq.pop_front(), reg_rdata_o);
		end
	end
	initial begin
		{reg_wr_i, reg_rd_i, latch, ext_sel, rst_n_i, src} = 10'h0;
		{reg_addr_i, reg_wdata_i, lower} = 19'h0;
		ident = 8'hc4;
		lfsr = 8'h2f;
		repeat (8) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		bus(0, 3'h1, 8'h00);
		bus(0, 3'h2, 8'h01);
		chk("thr", 8'h01, {3'h0, rx_threshold_o});
		chk("flags", 8'h01, {6'h0, queues_enable_o, ident_inhibit_o});
		latch = 1'b1;
		bus(0, 3'h1, 8'h00);
		lfsr = lfsr_next(lfsr);
		bus(1, 3'h1, lfsr);
		bus(0, 3'h1, lfsr);
		latch = 1'b0;
		bus(0, 3'h1, 8'h00);
		bus(0, 3'h0, 8'h00);
		bus(0, 3'h7, 8'h00);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			lfsr = lfsr_next(lfsr);
			ident = lfsr;
			bus(1, 3'h1, 8'h01 << i | 8'hf0);
			bus(0, 3'h1, 8'h01 << i);
			bus(0, 3'h2, lfsr);
			src = 5'h01 << i;
			wait_chk("irq on", 1'b1);
			src = ~src;
			wait_chk("irq off", 1'b0);
		end
		bus(1, 3'h1, 8'h00);
		src = 5'h1f;
		wait_chk("quiet", 1'b0);
		bus(0, 3'h2, 8'h01);
		src = 5'h00;
		$display("test interrupts done");
		for (int c = 0; c < 4; c++) begin
			lfsr = lfsr_next(lfsr);
			bus(1, 3'h2, {c[1:0], 2'h0, lfsr[3], 3'h7});
			chk("fcr", {3'h7, thr_tab[c]}, {tx_queue_flush_o, rx_queue_flush_o,
				queues_enable_o, rx_threshold_o});
			@(negedge ref_clk_i);
			chk("self", 8'h00, {6'h0, tx_queue_flush_o, rx_queue_flush_o});
		end
		bus(1, 3'h2, 8'h46);
		chk("off", 8'hce, {tx_queue_flush_o, rx_queue_flush_o, queues_enable_o,
			rx_threshold_o});
		bus(1, 3'h2, 8'h01);
		bus(1, 3'h1, 8'h01);
		src = 5'h10;
		wait_chk("timeout", 1'b1);
		bus(1, 3'h2, 8'h00);
		wait_chk("timeout off", 1'b0);
		src = 5'h00;
		$display("test queues done");
		// Mid-run reset must clear enables and the upper divisor
		rst_n_i = 1'b0;
		@(negedge ref_clk_i);
		rst_n_i = 1'b1;
		chk("reset", 8'h01,
			{6'h0, queues_enable_o, ident_inhibit_o});
		latch = 1'b1;
		bus(0, 3'h1, 8'h00);
		$display("test reset done");
		latch = 1'b1;
		lower = 8'h01;
		bus(1, 3'h1, 8'h00);
		count(ns);
		bus(1, 3'h1, 8'h80);
		count(nf);
		ext_sel = 1'b1;
		count(nx);
		chk("rates", 8'h03, {6'h0, nf > ns, nx > ns && nx < nf});
		// Divisor 2 on the external clock gives half the ticks
		lower = 8'h02;
		count(n2);
		chk("div2", 8'h01, {7'h0, n2 * 2 >= nx - 4
			&& n2 * 2 <= nx + 4});
		lower = 8'h00;
		bus(1, 3'h1, 8'h00);
		count(nx);
		chk("div0", 8'h00, nx[7:0]);
		$display("test baud done");
		finish_test();
	end
endmodule : testbench
bind ubf_ctrl ubf_ctrl_asserts ubf_ctrl_asserts_inst (.*);

// *** tb/ubf_ctrl_asserts.sv ***
// Checker for ubf_ctrl queue control, reads and interrupt gating.
// Assumes binding into ubf_ctrl; sees its ports only.
`timescale 1ns/1ps
module ubf_ctrl_asserts (
	// Clock, reset, bus and identification input
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] interrupt_ident_i,
	// Watched outputs
	input wire logic [7:0] reg_rdata_o,
	input wire logic irq_o,
	input wire logic ident_inhibit_o,
	input wire logic queues_enable_o,
	input wire logic tx_queue_flush_o,
	input wire logic rx_queue_flush_o,
	input wire logic [4:0] rx_threshold_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire fcr_wr = reg_wr_i && reg_addr_i == 3'h2;
	logic [4:0] thr_exp;
	always_ff @(posedge ref_clk_i)
		thr_exp <= reg_wdata_i[7] ? (reg_wdata_i[6] ? 5'h0e : 5'h08)
			: (reg_wdata_i[6] ? 5'h04 : 5'h01);
	rx_flush_a: assert property (
		fcr_wr && reg_wdata_i[1:0] == 2'h3 |=> rx_queue_flush_o)
		else $error("rx flush missing");
	tx_flush_a: assert property (
		fcr_wr && reg_wdata_i[2] && reg_wdata_i[0] |=> tx_queue_flush_o)
		else $error("tx flush missing");
	queue_off_a: assert property (
		fcr_wr && !reg_wdata_i[0] |=> tx_queue_flush_o && rx_queue_flush_o)
		else $error("disable did not empty queues");
	queue_en_a: assert property (
		fcr_wr |=> queues_enable_o == $past(reg_wdata_i[0]))
		else $error("queue enable wrong");
	thresh_a: assert property (
		fcr_wr && reg_wdata_i[0] |=> rx_threshold_o == thr_exp)
		else $error("threshold wrong");
	ident_rd_a: assert property (
		reg_rd_i && reg_addr_i == 3'h2 && !ident_inhibit_o
		|=> reg_rdata_o == $past(interrupt_ident_i))
		else $error("ident read wrong");
	irq_quiet_a: assert property (
		ident_inhibit_o && $past(ident_inhibit_o) |-> !irq_o)
		else $error("irq while disabled");
	unmapped_rd_a: assert property (
		reg_rd_i && reg_addr_i != 3'h1 && reg_addr_i != 3'h2
		|=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule : ubf_ctrl_asserts

// *** tb/ubf_far_model.sv ***
// Far side: three free-running baud clock sources.
// Assumes nothing of the bench clock; phases are unrelated.
`timescale 1ns/1ps
module ubf_far_model (
	// Baud clock pins
	output logic slow_clk_o,
	output logic fast_clk_o,
	output logic ext_clk_o
);
	// Rates chosen so slow < external < fast; one process per pin
	initial begin
		slow_clk_o = 1'b0;
		forever #47 slow_clk_o = !slow_clk_o;
	end
	initial begin
		fast_clk_o = 1'b0;
		forever #13 fast_clk_o = !fast_clk_o;
	end
	initial begin
		ext_clk_o = 1'b0;
		forever #29 ext_clk_o = !ext_clk_o;
	end
endmodule : ubf_far_model
